//--- src/swdsl_baud_det.sv
// auto-baud detector: measures the low run of the reference character
`timescale 1ns/10ps
`default_nettype none
`include "swdsl_defines.svh"
module swdsl_baud_det
   import swdsl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic line_in,
   input wire logic baud_clr,
   output logic [9:0] bit_per,
   output logic baud_lock
);
   swdsl_bd_e st_ff;
   logic [15:0] cnt_ff;
   logic [9:0] per_ff;
   logic lock_ff;
   logic [9:0] cand;
   logic cand_ok;

   // reference 80h is low for start plus seven zeros: eight bits
   assign cand = cnt_ff[12:3];
   assign cand_ok = cand >= `SWDSL_PER_MIN && cand <= `SWDSL_PER_MAX;

   // arm on high line, measure the next low run
   always_ff @(posedge sys_clk) begin
      if (!resetn || baud_clr) begin
         st_ff <= bd_arm;
      end else begin
         unique case (st_ff)
            bd_arm: if (line_in) st_ff <= bd_idle;
            bd_idle: if (!line_in) st_ff <= bd_meas;
            bd_meas: if (line_in) st_ff <= cand_ok ? bd_lock : bd_idle;
            bd_lock: st_ff <= bd_lock;
         endcase
      end
   end

   // count of low cycles, saturating
   always_ff @(posedge sys_clk) begin
      if (!resetn || baud_clr) begin
         cnt_ff <= 16'h0000;
      end else if (st_ff == bd_idle) begin
         cnt_ff <= 16'h0001;
      end else if (st_ff == bd_meas && !line_in
                   && cnt_ff != `SWDSL_MEAS_MAX) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   // load the generator period at the rising end of the run
   always_ff @(posedge sys_clk) begin
      if (!resetn || baud_clr) begin
         per_ff <= 10'h000;
         lock_ff <= 1'b0;
      end else if (st_ff == bd_meas && line_in && cand_ok) begin
         per_ff <= cand; // [RULE1]
         lock_ff <= 1'b1; // [RULE2]
      end
   end

   assign bit_per = per_ff;
   assign baud_lock = lock_ff;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   lock_range_a: assert property (lock_ff |-> per_ff >= 10'h004 // [RULE4]
      && per_ff <= 10'h200)
      else $error("locked period outside supported range");
   lock_meas_a: assert property ($rose(lock_ff) |-> // [RULE1]
      per_ff == $past(cnt_ff[12:3]))
      else $error("period does not match measured run");
   clr_unlock_a: assert property (baud_clr |=> !lock_ff // [RULE5]
      && per_ff == 10'h000)
      else $error("baud reset did not clear the generator");
endmodule
`default_nettype wire

//--- src/swdsl_defines.svh
// timing, width and reset constants of the single wire debug link
`ifndef SWDSL_DEFINES_SVH
`define SWDSL_DEFINES_SVH
// fastest bit period: sys_clk / 4
`define SWDSL_PER_MIN 10'h004
// slowest bit period: sys_clk / 512
`define SWDSL_PER_MAX 10'h200
// saturation of the reference low run counter
`define SWDSL_MEAS_MAX 16'h1fff
// bit times of low line that make a break
`define SWDSL_BRK_BITS 16'h0009
// bit times of the returned break: four ten-bit characters
`define SWDSL_RET_BITS 16'h0028
// index of the stop bit in a character
`define SWDSL_LAST_BIT 4'h9
// reset value of the debugger control register
`define SWDSL_CTRL_RST 8'h00
`endif

//--- src/swdsl_link.sv
// serial front end of the on-chip debugger on the single debug pin
// ****************************************************************
// Overview of operation
// [RULE1] measure reference low run and load the baud generator from it
// [RULE2] run on sys_clk; periods up to 512 cycles per bit
// [RULE3] host should keep bit rate at or below sys_clk / 8
// [RULE4] periods below 4 cycles per bit are never accepted
// [RULE5] nine or more low bit times is a break; baud logic resets (the link judges a break at nine and a half)
// [RULE6] after a break the host sends 80h to re-measure the rate
// [RULE7] low stop bit raises a framing error
// [RULE8] line low while sending a one raises a transmit collision
// [RULE9] any error aborts, returns a four character break, resets baud
// [RULE10] host sends a break on attach and on error recovery
// [RULE11] break leaves the debugger control register untouched
// [RULE12] halt mode survives a break
// [RULE13] serial logic held in reset until the pin returns high
// [RULE14] open drain: host break may overlap, returned break extends low
// [RULE15] frame: low start, eight data bits lsb first, high stop
// [RULE16] sample mid-bit and never drive while receiving
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "swdsl_defines.svh"
module swdsl_link
   import swdsl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic debug_serial_pin_i,
   output logic debug_serial_pin_o,
   output logic debug_serial_pin_oe_n,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   output logic [7:0] ctrl_q,
   input wire logic halt_set,
   input wire logic halt_clr,
   output logic halt_mode,
   output logic cmd_abort,
   output logic err_break,
   output logic err_frame,
   output logic err_collision,
   output logic baud_locked,
   output logic link_in_reset
);
   swdsl_state_e state_ff, nxt_state;
   logic line, line_d_ff, fall, tick, in_brk, cnt_low;
   logic locked, baud_clr;
   logic [9:0] per, per_eff, tmr_ff;
   logic [3:0] bit_ff;
   logic [9:0] tx_sh_ff;
   logic [7:0] rx_sh_ff, rx_data_ff, ctrl_ff;
   logic [15:0] low_ff, brk_tmr_ff, brk_lim, ret_len;
   logic brk_hit, frame_hit, coll_hit, err, accept;
   logic oe_n_ff, pin_o_ff, tx_ready_ff, rx_valid_ff, halt_ff;
   logic abort_ff, err_brk_ff, err_frm_ff, err_col_ff;
   logic lock_ff, in_rst_ff;

   // ************************************************
   // pin input and baud generator
   // ************************************************
   swdsl_sync u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .d(debug_serial_pin_i),
      .q(line)
   );

   // held in reset while waiting for the pin to rise
   assign baud_clr = state_ff == st_brk_wait; // [RULE5] [RULE13]

   swdsl_baud_det u_baud (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .line_in(line),
      .baud_clr(baud_clr),
      .bit_per(per),
      .baud_lock(locked)
   );

   // unlocked link times breaks at the slowest rate
   assign per_eff = locked ? per : `SWDSL_PER_MAX; // [RULE2]
   assign brk_lim = swdsl_scale(per_eff, `SWDSL_BRK_BITS)
                    + {7'h00, per_eff[9:1]};
   assign ret_len = swdsl_scale(per_eff, `SWDSL_RET_BITS);

   // ************************************************
   // event detection
   // ************************************************
   assign fall = line_d_ff && !line;
   assign tick = tmr_ff == 10'h000;
   assign in_brk = state_ff == st_brk_out || state_ff == st_brk_wait;
   assign cnt_low = state_ff == st_detect || state_ff == st_idle
                    || state_ff == st_rx;
   // break judged half a bit past nine, so a 00h char never trips it
   assign brk_hit = cnt_low && low_ff >= brk_lim; // [RULE5]
   assign frame_hit = state_ff == st_rx && tick
                      && bit_ff == `SWDSL_LAST_BIT && !line; // [RULE7]
   // own drive reaches the synchroniser by the end of each bit
   assign coll_hit = state_ff == st_tx && tick && tx_sh_ff[0]
                     && !line; // [RULE8] [RULE14]
   assign err = (brk_hit || frame_hit || coll_hit) && !in_brk;
   assign accept = state_ff == st_idle && !fall && tx_valid
                   && tx_ready_ff;

   // previous line level for start edge detection
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         line_d_ff <= 1'b1;
      end else begin
         line_d_ff <= line;
      end
   end

   // run length of low line while listening
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         low_ff <= 16'h0000;
      end else if (cnt_low && !line) begin
         if (low_ff != 16'hffff) low_ff <= low_ff + 16'h0001;
      end else begin
         low_ff <= 16'h0000;
      end
   end

   // ************************************************
   // main sequencer
   // ************************************************
   always_comb begin
      nxt_state = state_ff;
      if (err) begin
         nxt_state = st_brk_out; // [RULE9]
      end else begin
         unique case (state_ff)
            st_detect: if (locked) nxt_state = st_idle; // [RULE6]
            st_idle: begin
               if (fall) nxt_state = st_rx;
               else if (accept) nxt_state = st_tx;
            end
            st_rx: begin
               if (tick && bit_ff == 4'h0 && line) nxt_state = st_idle;
               else if (tick && bit_ff == `SWDSL_LAST_BIT)
                  nxt_state = st_idle;
            end
            st_tx: begin
               if (tick && bit_ff == `SWDSL_LAST_BIT) nxt_state = st_idle;
            end
            st_brk_out: if (brk_tmr_ff == 16'h0000) nxt_state = st_brk_wait;
            st_brk_wait: if (line) nxt_state = st_detect; // [RULE13]
            default: nxt_state = st_detect;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_ff <= st_detect;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // bit timer: half period to mid start bit, then full periods
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         tmr_ff <= 10'h000;
      end else if (state_ff == st_idle) begin
         tmr_ff <= fall ? per_eff >> 1 : per_eff - 10'h001; // [RULE16]
      end else if (state_ff == st_rx || state_ff == st_tx) begin
         tmr_ff <= tick ? per_eff - 10'h001 : tmr_ff - 10'h001;
      end else begin
         tmr_ff <= 10'h000;
      end
   end

   // bit index within the character
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         bit_ff <= 4'h0;
      end else if (state_ff == st_rx || state_ff == st_tx) begin
         if (tick) bit_ff <= bit_ff + 4'h1;
      end else begin
         bit_ff <= 4'h0;
      end
   end

   // ************************************************
   // receive and transmit data paths
   // ************************************************
   // receive shift register, lsb arrives first
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rx_sh_ff <= 8'h00;
      end else if (state_ff == st_rx && tick && bit_ff != 4'h0
                   && bit_ff != `SWDSL_LAST_BIT) begin
         rx_sh_ff <= {line, rx_sh_ff[7:1]}; // [RULE15]
      end
   end

   // deliver a character whose stop bit is high
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rx_data_ff <= 8'h00;
         rx_valid_ff <= 1'b0;
      end else begin
         rx_valid_ff <= 1'b0;
         if (state_ff == st_rx && tick && bit_ff == `SWDSL_LAST_BIT
             && line && !err) begin
            rx_data_ff <= rx_sh_ff;
            rx_valid_ff <= 1'b1;
         end
      end
   end

   // transmit shift: stop, data, start; ones shifted in behind
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         tx_sh_ff <= 10'h3ff;
      end else if (accept && !err) begin
         tx_sh_ff <= {1'b1, tx_data, 1'b0}; // [RULE15]
      end else if (state_ff == st_tx && tick) begin
         tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
      end
   end

   // returned break length counter
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         brk_tmr_ff <= 16'h0000;
      end else if (err) begin
         brk_tmr_ff <= ret_len - 16'h0001; // [RULE9]
      end else if (state_ff == st_brk_out && brk_tmr_ff != 16'h0000) begin
         brk_tmr_ff <= brk_tmr_ff - 16'h0001;
      end
   end

   // ************************************************
   // pin drive: pull low only, release otherwise
   // ************************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         oe_n_ff <= 1'b1;
         pin_o_ff <= 1'b0;
      end else begin
         pin_o_ff <= 1'b0;
         // receive, detect and wait states never drive
         oe_n_ff <= !((state_ff == st_tx && !tx_sh_ff[0])
                      || state_ff == st_brk_out); // [RULE16] [RULE14]
      end
   end

   // ************************************************
   // status and controller-facing outputs
   // ************************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         abort_ff <= 1'b0;
         err_brk_ff <= 1'b0;
         err_frm_ff <= 1'b0;
         err_col_ff <= 1'b0;
      end else begin
         abort_ff <= err; // [RULE9]
         err_brk_ff <= brk_hit && !in_brk;
         err_frm_ff <= frame_hit && !in_brk;
         err_col_ff <= coll_hit && !in_brk;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         tx_ready_ff <= 1'b0;
         lock_ff <= 1'b0;
         in_rst_ff <= 1'b0;
      end else begin
         tx_ready_ff <= nxt_state == st_idle;
         lock_ff <= locked;
         in_rst_ff <= nxt_state == st_brk_out
                      || nxt_state == st_brk_wait; // [RULE13]
      end
   end

   // control register: only the controller writes it
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctrl_ff <= `SWDSL_CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_ff <= ctrl_wdata; // [RULE11]
      end
   end

   // halt mode: errors and breaks leave it alone
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         halt_ff <= 1'b0;
      end else if (halt_set) begin
         halt_ff <= 1'b1; // [RULE12]
      end else if (halt_clr) begin
         halt_ff <= 1'b0;
      end
   end

   assign debug_serial_pin_o = pin_o_ff;
   assign debug_serial_pin_oe_n = oe_n_ff;
   assign tx_ready = tx_ready_ff;
   assign rx_data = rx_data_ff;
   assign rx_valid = rx_valid_ff;
   assign ctrl_q = ctrl_ff;
   assign halt_mode = halt_ff;
   assign cmd_abort = abort_ff;
   assign err_break = err_brk_ff;
   assign err_frame = err_frm_ff;
   assign err_collision = err_col_ff;
   assign baud_locked = lock_ff;
   assign link_in_reset = in_rst_ff;

   // ************************************************
   // checks
   // ************************************************
   logic [15:0] brk_cyc_ff;
   always_ff @(posedge sys_clk) begin
      if (!resetn || state_ff != st_brk_out) begin
         brk_cyc_ff <= 16'h0000;
      end else begin
         brk_cyc_ff <= brk_cyc_ff + 16'h0001;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence brk_entry_s;
      state_ff != st_brk_out ##1 state_ff == st_brk_out;
   endsequence
   sequence brk_leave_s;
      state_ff == st_brk_out && nxt_state == st_brk_wait;
   endsequence

   rx_no_drive_a: assert property (state_ff == st_rx // [RULE16]
      && $past(state_ff) == st_rx |-> debug_serial_pin_oe_n)
      else $error("pin driven while receiving");
   brk_drive_a: assert property (brk_entry_s ##1 // [RULE9]
      state_ff == st_brk_out |-> !debug_serial_pin_oe_n)
      else $error("returned break not driven low");
   brk_len_a: assert property (brk_leave_s |-> // [RULE9]
      brk_cyc_ff + 16'h0001 == ret_len)
      else $error("returned break length wrong");
   frame_abort_a: assert property (frame_hit && !in_brk |=> // [RULE7]
      err_frame && cmd_abort && state_ff == st_brk_out)
      else $error("framing error not flagged and aborted");
   coll_flag_a: assert property (coll_hit && !in_brk |=> // [RULE8]
      err_collision ##0 cmd_abort)
      else $error("collision not flagged");
   brk_flag_a: assert property (brk_hit && !in_brk |=> // [RULE5]
      err_break && link_in_reset ##1 state_ff == st_brk_out)
      else $error("break not detected");
   hold_rst_a: assert property (state_ff == st_brk_wait && !line // [RULE13]
      |=> state_ff == st_brk_wait && link_in_reset)
      else $error("left reset before pin high");
   ctrl_keep_a: assert property (in_brk && !ctrl_wr |=> // [RULE11]
      $stable(ctrl_q))
      else $error("control register changed by break");
   halt_keep_a: assert property (in_brk && halt_mode && !halt_clr // [RULE12]
      |=> halt_mode)
      else $error("halt mode lost in break");
endmodule
`default_nettype wire

//--- src/swdsl_pkg.sv
// types and shared arithmetic of the single wire debug link
package swdsl_pkg;

   typedef enum logic [2:0] {
      st_detect = 3'b000,
      st_idle = 3'b001,
      st_rx = 3'b010,
      st_tx = 3'b011,
      st_brk_out = 3'b100,
      st_brk_wait = 3'b101
   } swdsl_state_e;

   typedef enum logic [1:0] {
      bd_arm = 2'b00,
      bd_idle = 2'b01,
      bd_meas = 2'b10,
      bd_lock = 2'b11
   } swdsl_bd_e;

   // bit period times a number of bits, in cycles
   function automatic logic [15:0] swdsl_scale(input logic [9:0] per,
                                               input logic [15:0] k);
      logic [31:0] p;
      p = {22'h000000, per} * {16'h0000, k};
      return p[15:0];
   endfunction

endpackage

//--- src/swdsl_sync.sv
// two-stage synchroniser for the debug pin
`timescale 1ns/10ps
`default_nettype none
module swdsl_sync (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic d,
   output logic q
);
   logic meta_ff;
   logic q_ff;

   // line idles high, so both stages reset high
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         meta_ff <= 1'b1;
         q_ff <= 1'b1;
      end else begin
         meta_ff <= d;
         q_ff <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule
`default_nettype wire

//--- tb/swdsl_host.sv
// host debug adapter model on the open-drain debug pin
`timescale 1ns/10ps
`default_nettype none
module swdsl_host (
   input wire logic sys_clk,
   output var logic host_low
);
   // released line floats to the pull-up
   initial host_low = 1'b0;

   // hold one level for n cycles, pulling low for a zero
   task automatic drive(input logic lvl, input int n);
      host_low <= ~lvl;
      repeat (n) @(posedge sys_clk);
   endtask

   // one frame; a low stop is sent only when a test asks for it
   task automatic send_char(input logic [7:0] d, input logic stop,
                            input int p);
      drive(1'b0, p);
      for (int i = 0; i < 8; i++) begin
         drive(d[i], p);
      end
      drive(stop, p);
      drive(1'b1, 1);
   endtask

   // reference character for the baud detector
   task automatic reference(input int p);
      send_char(8'h80, 1'b1, p);
   endtask

   // break on attach or on error recovery, released by the caller
   task automatic send_break(input int n);
      drive(1'b0, n);
   endtask
endmodule
`default_nettype wire

//--- tb/swdsl_link_bench.sv
// self-checking bench of the single wire debug link
`timescale 1ns/10ps
`default_nettype none
module swdsl_link_bench;
   logic sys_clk, resetn, host_low, pin_wire;
   logic [7:0] tx_data, ctrl_wdata, rx_data, ctrl_q, rx_last;
   logic tx_valid, ctrl_wr, halt_set, halt_clr, tx_ready, rx_valid;
   logic debug_serial_pin_o, debug_serial_pin_oe_n, halt_mode;
   logic cmd_abort, err_break, err_frame, err_collision;
   logic baud_locked, link_in_reset;
   int bad_count, total_checks, n_rx, n_frame, n_brk, n_col, n_abort;
   int oe_low, run, last_run;

   // ****************************************
   // clock, wire and instances
   // ****************************************
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   // open-drain wire with pull-up
   assign pin_wire = (host_low === 1'b1) ? 1'b0 :
      (debug_serial_pin_oe_n === 1'b0) ? debug_serial_pin_o : 1'b1;

   swdsl_link swdsl_link_i (
      .sys_clk(sys_clk), .resetn(resetn),
      .debug_serial_pin_i(pin_wire),
      .debug_serial_pin_o(debug_serial_pin_o),
      .debug_serial_pin_oe_n(debug_serial_pin_oe_n),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .ctrl_q(ctrl_q), .halt_set(halt_set),
      .halt_clr(halt_clr), .halt_mode(halt_mode), .cmd_abort(cmd_abort),
      .err_break(err_break), .err_frame(err_frame),
      .err_collision(err_collision), .baud_locked(baud_locked),
      .link_in_reset(link_in_reset)
   );

   swdsl_host swdsl_host_i (.sys_clk(sys_clk), .host_low(host_low));

   // pulse counters and length of the last low drive
   always @(posedge sys_clk) begin
      if (err_frame === 1'b1) n_frame <= n_frame + 1;
      if (err_break === 1'b1) n_brk <= n_brk + 1;
      if (err_collision === 1'b1) n_col <= n_col + 1;
      if (cmd_abort === 1'b1) n_abort <= n_abort + 1;
      if (rx_valid === 1'b1) begin
         n_rx <= n_rx + 1;
         rx_last <= rx_data;
      end
      if (debug_serial_pin_oe_n === 1'b0) begin
         oe_low <= oe_low + 1;
         run <= run + 1;
      end else begin
         if (run != 0) last_run <= run;
         run <= 0;
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic fail(input string m);
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
   endtask

   task automatic chk_bit(input logic got, input logic exp, string m);
      total_checks++;
      if (got !== exp) fail(m);
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                           input string m);
      total_checks++;
      if (got !== exp) fail(m);
   endtask

   task automatic chk_num(input int got, input int exp, input string m);
      total_checks++;
      if (got != exp) fail(m);
   endtask

   // hand one character over and wait for its start bit
   task automatic start_tx(input logic [7:0] d);
      int n;
      n = 0;
      tx_data <= d;
      tx_valid <= 1'b1;
      @(posedge sys_clk);
      while (tx_ready !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      tx_valid <= 1'b0;
      while (debug_serial_pin_oe_n !== 1'b0 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      chk_bit(debug_serial_pin_oe_n, 1'b0, "no start bit");
   endtask

   // wait out the returned break and the pin going high
   task automatic recover(input int p);
      int n;
      n = 0;
      chk_bit(link_in_reset, 1'b1, "not in reset");
      while (link_in_reset !== 1'b0 && n < 45 * p + 100) begin
         @(posedge sys_clk);
         n++;
      end
      chk_bit(link_in_reset, 1'b0, "reset stuck");
      chk_num(last_run, 40 * p, "returned break length");
      cyc(2);
      chk_bit(baud_locked, 1'b0, "baud kept");
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_calib(input int p, input logic exp);
      swdsl_host_i.reference(p);
      cyc(4);
      chk_bit(baud_locked, exp, "lock");
      chk_bit(tx_ready, exp, "ready after lock");
   endtask

   task automatic t_rx(input logic [7:0] d, input int p);
      int r0, o0;
      r0 = n_rx;
      o0 = oe_low;
      swdsl_host_i.send_char(d, 1'b1, p);
      cyc(4);
      chk_num(n_rx, r0 + 1, "rx count");
      chk_byte(rx_last, d, "rx data");
      chk_num(oe_low, o0, "drove while receiving");
   endtask

   task automatic t_tx(input logic [7:0] d, input int p);
      logic [9:0] f;
      int n;
      n = 0;
      start_tx(d);
      cyc(p / 2 - 1);
      for (int i = 0; i < 10; i++) begin
         f[i] = pin_wire;
         cyc(p);
      end
      chk_bit(f[0], 1'b0, "tx start");
      chk_byte(f[8:1], d, "tx data");
      chk_bit(f[9], 1'b1, "tx stop");
      while (tx_ready !== 1'b1 && n < 3 * p) begin
         @(posedge sys_clk);
         n++;
      end
      chk_bit(tx_ready, 1'b1, "tx done");
   endtask

   task automatic t_collide(input int p);
      int c0, a0;
      c0 = n_col;
      a0 = n_abort;
      start_tx(8'hff);
      cyc(p + p / 2 - 1);
      swdsl_host_i.drive(1'b0, p);
      swdsl_host_i.drive(1'b1, 1);
      chk_num(n_col, c0 + 1, "collision");
      chk_num(n_abort, a0 + 1, "abort on collision");
      recover(p);
   endtask

   task automatic t_frame(input int p);
      int f0, a0, r0;
      f0 = n_frame;
      a0 = n_abort;
      r0 = n_rx;
      swdsl_host_i.send_char(8'h55, 1'b0, p);
      cyc(2);
      chk_num(n_frame, f0 + 1, "frame error");
      chk_num(n_abort, a0 + 1, "abort on frame");
      chk_num(n_rx, r0, "bad frame delivered");
      recover(p);
   endtask

   task automatic t_break(input int p, input int hold);
      int b0, a0;
      ctrl_wdata <= 8'h5a;
      ctrl_wr <= 1'b1;
      halt_set <= 1'b1;
      cyc(1);
      ctrl_wr <= 1'b0;
      halt_set <= 1'b0;
      cyc(1);
      b0 = n_brk;
      a0 = n_abort;
      swdsl_host_i.send_break(hold);
      chk_bit(link_in_reset, 1'b1, "reset during break");
      chk_num(n_brk, b0 + 1, "break seen");
      chk_num(n_abort, a0 + 1, "abort on break");
      swdsl_host_i.drive(1'b1, 1);
      recover(p);
      chk_byte(ctrl_q, 8'h5a, "control lost");
      chk_bit(halt_mode, 1'b1, "halt lost");
      halt_clr <= 1'b1;
      cyc(1);
      halt_clr <= 1'b0;
      cyc(1);
      chk_bit(halt_mode, 1'b0, "halt clear");
   endtask

   // ****************************************
   // verdict, watchdog and main sequence
   // ****************************************
   task automatic conclude();
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // cut a hang short
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail("timeout");
      conclude();
   end

   // stimulus
   initial begin
      {bad_count, total_checks, n_rx, n_frame, n_brk} = '0;
      {n_col, n_abort, oe_low, run, last_run} = '0;
      resetn = 1'b0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      ctrl_wdata = 8'h00;
      ctrl_wr = 1'b0;
      halt_set = 1'b0;
      halt_clr = 1'b0;
      cyc(5);
      resetn <= 1'b1;
      cyc(1);
      chk_bit(debug_serial_pin_oe_n, 1'b1, "pin driven at reset");
      chk_bit(debug_serial_pin_o, 1'b0, "pin value not low");
      chk_bit(baud_locked, 1'b0, "locked at reset");
      chk_byte(ctrl_q, 8'h00, "control reset");
      t_calib(512, 1'b1);
      t_rx(8'hc3, 512);
      t_break(512, 5120);
      t_calib(8, 1'b1);
      t_rx(8'ha5, 8);
      t_tx(8'h3c, 8);
      t_collide(8);
      t_calib(8, 1'b1);
      t_frame(8);
      t_calib(4, 1'b1);
      t_rx(8'h5a, 4);
      t_tx(8'h96, 4);
      t_break(4, 200);
      t_calib(3, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
